//--- hdl/vsw_pkg.sv
// Constants and types shared by the inbound VMEbus slave window
package vsw_pkg;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] VSW_CTL_OFS = 12'hFCC;
   localparam logic [11:0] VSW_BASE_OFS = 12'hFD0;
   localparam logic [11:0] VSW_BOUND_OFS = 12'hFD4;
   localparam logic [11:0] VSW_XOFS_OFS = 12'hFD8;
   localparam logic [11:0] VSW_STAT_OFS = 12'hFDC;

   // ------------------------------------------------------------
   // Control register fields and resets
   // ------------------------------------------------------------
   localparam int VSW_EN_BIT = 31;
   localparam int VSW_POST_BIT = 30;
   localparam int VSW_PREF_BIT = 29;
   localparam int VSW_PROG_LSB = 22;
   localparam int VSW_PRIV_LSB = 20;
   localparam int VSW_VSP_LSB = 16;
   localparam int VSW_WIDE_BIT = 7;
   localparam int VSW_LOCK_BIT = 6;
   localparam int VSW_PSP_LSB = 0;
   localparam int VSW_HALF_LSB = 16;
   localparam int VSW_CNT_LSB = 8;
   localparam logic [31:0] VSW_CTL_WMASK = 32'hE0F700C3;
   localparam logic [31:0] VSW_CTL_RESET = 32'h00F00000;
   localparam logic [15:0] VSW_HALF_RESET = 16'h0000;

   // ------------------------------------------------------------
   // Space and qualifier encodings
   // ------------------------------------------------------------
   localparam logic [2:0] VSW_SP_A24 = 3'h1;
   localparam logic [2:0] VSW_SP_A32 = 3'h2;
   localparam logic [2:0] VSW_SP_USR1 = 3'h6;
   localparam logic [2:0] VSW_SP_USR2 = 3'h7;
   localparam logic [2:0] VSW_SP_NONE = 3'h0;
   localparam logic [1:0] VSW_PCI_MEM = 2'h0;
   localparam logic [1:0] VSW_PCI_IO = 2'h1;
   localparam logic [1:0] VSW_PCI_CFG = 2'h2;
   localparam logic [2:0] VSW_AM_A24_HI = 3'h7;
   localparam logic [2:0] VSW_AM_A32_HI = 3'h1;
   localparam logic [1:0] VSW_AM_USER_HI = 2'h1;
   localparam logic [1:0] VSW_AM_PROG_LO = 2'h2;
   localparam int VSW_AM_SUP_BIT = 2;
   localparam int VSW_AM_USR2_BIT = 3;

   typedef enum logic [1:0] {VSW_IDLE, VSW_ISSUE, VSW_REPLY} vsw_state_t;

endpackage : vsw_pkg

//--- hdl/vsw_cfg_if.sv
// Window settings carried from the register file to decode and translation
`timescale 1ns/1ns
`default_nettype none
interface vsw_cfg_if;
   logic enable;
   logic [1:0] progSel;
   logic [1:0] privSel;
   logic [2:0] spaceSel;
   logic [15:0] base;
   logic [15:0] bound;
   logic [15:0] offset;

   modport src (output enable, progSel, privSel, spaceSel, base, bound, offset);
   modport sink (input enable, progSel, privSel, spaceSel, base, bound, offset);
endinterface : vsw_cfg_if
`default_nettype wire

//--- hdl/vsw_decode.sv
// Address-space, modifier and range match of one inbound cycle
`timescale 1ns/1ns
`default_nettype none
module vsw_decode (
   // Settings
   vsw_cfg_if.sink cfg,
   // Inbound cycle
   input wire logic [31:0] addr,
   input wire logic [5:0] am,
   // Result
   output logic hit
);
   import vsw_pkg::*;

   // ------------------------------------------------------------
   // Modifier to space
   // ------------------------------------------------------------
   function automatic logic [2:0] amSpace(input logic [5:0] m);
      if (m[5:3] == VSW_AM_A24_HI) return VSW_SP_A24;
      if (m[5:3] == VSW_AM_A32_HI) return VSW_SP_A32;
      if (m[5:4] == VSW_AM_USER_HI) return m[VSW_AM_USR2_BIT] ? VSW_SP_USR2 : VSW_SP_USR1;
      return VSW_SP_NONE;
   endfunction : amSpace

   logic spaceOk;
   logic progOk;
   logic privOk;
   logic aboveBase;
   logic belowBound;

   always_comb begin
      spaceOk = (amSpace(am) == cfg.spaceSel) && (cfg.spaceSel != VSW_SP_NONE);
      // program/data qualifier; code 00 accepts nothing
      progOk = cfg.progSel[am[1:0] == VSW_AM_PROG_LO];
      privOk = cfg.privSel[am[VSW_AM_SUP_BIT]];
      // base is the lowest address decoded
      aboveBase = addr[31:16] >= cfg.base;
      belowBound = (cfg.bound == VSW_HALF_RESET) || (addr[31:16] < cfg.bound);
      hit = cfg.enable && spaceOk && progOk && privOk && aboveBase && belowBound;
   end

endmodule : vsw_decode
`default_nettype wire

//--- hdl/vsw_xlate.sv
// Translation of a decoded address into the PCI destination address
`timescale 1ns/1ns
`default_nettype none
module vsw_xlate (
   // Settings
   vsw_cfg_if.sink cfg,
   // Addresses
   input wire logic [31:0] srcAddr,
   output logic [31:0] dstAddr
);
   import vsw_pkg::*;

   // Same-width add wraps by itself; no carry is kept
   function automatic logic [15:0] addHalf(input logic [15:0] a, input logic [15:0] b);
      return a + b;
   endfunction : addHalf

   // low half passes, upper half wraps
   assign dstAddr = {addHalf(srcAddr[31:16], cfg.offset), srcAddr[15:0]};

endmodule : vsw_xlate
`default_nettype wire

//--- hdl/vsw_window.sv
// Inbound VMEbus slave window: registers, decode and PCI forwarding
// ------------------------------------------------------------
// What this block does
// - Window claims cycles only while enabled
// - Posting enable completes writes before PCI
// - Prefetch enable marks reads for prefetch
// - Program/data selector qualifies address modifier
// - Privilege selector qualifies address modifier
// - Space selector picks A24, A32, user spaces
// - Wide enable allows 64-bit PCI transactions
// - Lock enable holds PCI lock through RMW
// - PCI space selector: memory, I/O, configuration
// - No response without PCI bus-master enable
// - Posting, prefetch ignored outside memory space
// - Only memory-space cycles are decoupled
// - Base is lowest decoded address
// - Decode base up to below bound
// - Zero bound means no upper limit
// - Destination is address plus offset
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module vsw_window #(
   parameter int CNT_W = 8
) (
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // System control
   input wire logic vmeBusReset,
   input wire logic busMasterEnable,
   // Inbound VMEbus cycle
   input wire logic vmeReq,
   input wire logic [31:0] vmeAddr,
   input wire logic [5:0] vmeAm,
   input wire logic vmeWrite,
   input wire logic vmeRmw,
   input wire logic [31:0] vmeWdata,
   output logic vmeClaim,
   output logic vmeAck,
   output logic [31:0] vmeRdata,
   // PCI master request
   output logic pciReq,
   output logic [31:0] pciAddr,
   output logic [1:0] pciSpace,
   output logic pciWrite,
   output logic [31:0] pciWdata,
   output logic pciWide,
   output logic pciLock,
   output logic pciPrefetch,
   output logic pciPosted,
   input wire logic pciDone,
   input wire logic [31:0] pciRdata
);
   import vsw_pkg::*;

   if (CNT_W < 1 || CNT_W > 8) begin : gCntCheck
      $error("CNT_W must be 1 to 8");
   end

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [31:0] ctl_r;
   logic [31:0] ctl_nxt;
   logic [15:0] base_r;
   logic [15:0] base_nxt;
   logic [15:0] bound_r;
   logic [15:0] bound_nxt;
   logic [15:0] xofs_r;
   logic [15:0] xofs_nxt;
   logic wrPend_r;
   logic wrPend_nxt;
   logic [11:0] wrAddr_r;
   logic [11:0] wrAddr_nxt;
   logic [31:0] rdData_r;
   logic [31:0] rdData_nxt;
   logic addrPhase;

   // ------------------------------------------------------------
   // Cycle state
   // ------------------------------------------------------------
   vsw_state_t state_r;
   vsw_state_t state_nxt;
   logic [31:0] addr_r;
   logic [31:0] addr_nxt;
   logic [1:0] space_r;
   logic [1:0] space_nxt;
   logic write_r;
   logic write_nxt;
   logic [31:0] wdata_r;
   logic [31:0] wdata_nxt;
   logic [31:0] vrd_r;
   logic [31:0] vrd_nxt;
   logic wide_r;
   logic wide_nxt;
   logic lock_r;
   logic lock_nxt;
   logic pref_r;
   logic pref_nxt;
   logic posted_r;
   logic posted_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic hit;
   logic [31:0] xAddr;
   logic memSpace;

   // ------------------------------------------------------------
   // Settings to decode and translation
   // ------------------------------------------------------------
   vsw_cfg_if cfg ();

   assign cfg.enable = ctl_r[VSW_EN_BIT];
   assign cfg.progSel = ctl_r[VSW_PROG_LSB +: 2];
   assign cfg.privSel = ctl_r[VSW_PRIV_LSB +: 2];
   assign cfg.spaceSel = ctl_r[VSW_VSP_LSB +: 3];
   assign cfg.base = base_r;
   assign cfg.bound = bound_r;
   assign cfg.offset = xofs_r;

   vsw_decode uDecode (
      .cfg (cfg.sink),
      .addr (vmeAddr),
      .am (vmeAm),
      .hit (hit)
   );

   vsw_xlate uXlate (
      .cfg (cfg.sink),
      .srcAddr (vmeAddr),
      .dstAddr (xAddr)
   );

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Reads see the value being written this cycle, so a read right
   // after a write never returns stale data
   function automatic logic [31:0] readMux(
      input logic [11:0] a,
      input logic [31:0] c,
      input logic [15:0] b,
      input logic [15:0] d,
      input logic [15:0] o,
      input logic [31:0] s
   );
      unique case (a)
         VSW_CTL_OFS: return c;
         VSW_BASE_OFS: return {b, VSW_HALF_RESET};
         VSW_BOUND_OFS: return {d, VSW_HALF_RESET};
         VSW_XOFS_OFS: return {o, VSW_HALF_RESET};
         VSW_STAT_OFS: return s;
         default: return 32'h00000000;
      endcase
   endfunction : readMux

   function automatic logic [31:0] statusWord(
      input vsw_state_t st,
      input logic lk,
      input logic ps,
      input logic [CNT_W-1:0] n
   );
      logic [31:0] w;
      w = 32'h00000000;
      w[0] = (st != VSW_IDLE);
      w[1] = lk;
      w[2] = ps;
      w[VSW_CNT_LSB +: CNT_W] = n;
      return w;
   endfunction : statusWord

   // ------------------------------------------------------------
   // AHB-Lite slave and registers
   // ------------------------------------------------------------
   // Zero wait states; a frozen block holds the bus off
   assign hreadyout = ce;
   assign hresp = 1'b0;
   assign hrdata = rdData_r;
   assign addrPhase = hsel && htrans[1] && hready;

   always_comb begin
      ctl_nxt = ctl_r;
      base_nxt = base_r;
      bound_nxt = bound_r;
      xofs_nxt = xofs_r;
      wrPend_nxt = addrPhase && hwrite;
      wrAddr_nxt = haddr[11:0];
      rdData_nxt = rdData_r;
      if (wrPend_r) begin
         unique case (wrAddr_r)
            VSW_CTL_OFS: ctl_nxt = hwdata & VSW_CTL_WMASK;
            VSW_BASE_OFS: base_nxt = hwdata[VSW_HALF_LSB +: 16];
            VSW_BOUND_OFS: bound_nxt = hwdata[VSW_HALF_LSB +: 16];
            VSW_XOFS_OFS: xofs_nxt = hwdata[VSW_HALF_LSB +: 16];
            default: ;
         endcase
      end
      if (addrPhase && !hwrite) begin
         rdData_nxt = readMux(haddr[11:0], ctl_nxt, base_nxt, bound_nxt, xofs_nxt,
            statusWord(state_r, lock_r, posted_r, cnt_r));
      end
      // All settings return to reset on a VMEbus reset
      if (vmeBusReset) begin
         ctl_nxt = VSW_CTL_RESET;
         base_nxt = VSW_HALF_RESET;
         bound_nxt = VSW_HALF_RESET;
         xofs_nxt = VSW_HALF_RESET;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         ctl_r <= VSW_CTL_RESET;
         base_r <= VSW_HALF_RESET;
         bound_r <= VSW_HALF_RESET;
         xofs_r <= VSW_HALF_RESET;
         wrPend_r <= 1'b0;
         wrAddr_r <= 12'h000;
         rdData_r <= 32'h00000000;
      end else if (ce) begin
         ctl_r <= ctl_nxt;
         base_r <= base_nxt;
         bound_r <= bound_nxt;
         xofs_r <= xofs_nxt;
         wrPend_r <= wrPend_nxt;
         wrAddr_r <= wrAddr_nxt;
         rdData_r <= rdData_nxt;
      end
   end

   // ------------------------------------------------------------
   // Inbound cycle sequencer
   // ------------------------------------------------------------
   // target space taken from the control register
   assign memSpace = ctl_r[VSW_PSP_LSB +: 2] == VSW_PCI_MEM;
   assign vmeClaim = (state_r == VSW_IDLE) && vmeReq && hit && busMasterEnable && ce;
   assign vmeAck = (state_r == VSW_REPLY) && ce;
   assign pciReq = (state_r == VSW_ISSUE) && ce;
   assign pciAddr = addr_r;
   assign pciSpace = space_r;
   assign pciWrite = write_r;
   assign pciWdata = wdata_r;
   assign pciWide = wide_r;
   assign pciLock = lock_r;
   assign pciPrefetch = pref_r;
   assign pciPosted = posted_r;
   assign vmeRdata = vrd_r;

   always_comb begin
      state_nxt = state_r;
      addr_nxt = addr_r;
      space_nxt = space_r;
      write_nxt = write_r;
      wdata_nxt = wdata_r;
      vrd_nxt = vrd_r;
      wide_nxt = wide_r;
      lock_nxt = lock_r;
      pref_nxt = pref_r;
      posted_nxt = posted_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         VSW_IDLE: begin
            // lock ends with the read-modify-write sequence
            if (!vmeRmw) lock_nxt = 1'b0;
            if (vmeClaim) begin
               addr_nxt = xAddr;
               space_nxt = ctl_r[VSW_PSP_LSB +: 2];
               write_nxt = vmeWrite;
               wdata_nxt = vmeWdata;
               wide_nxt = ctl_r[VSW_WIDE_BIT];
               lock_nxt = (vmeRmw && ctl_r[VSW_LOCK_BIT]) || (lock_r && vmeRmw);
               pref_nxt = !vmeWrite && ctl_r[VSW_PREF_BIT] && memSpace;
               posted_nxt = vmeWrite && ctl_r[VSW_POST_BIT] && memSpace;
               cnt_nxt = cnt_r + 1'b1;
               state_nxt = (vmeWrite && ctl_r[VSW_POST_BIT] && memSpace) ? VSW_REPLY : VSW_ISSUE;
            end
         end
         VSW_ISSUE: begin
            if (pciDone) begin
               if (!write_r) vrd_nxt = pciRdata;
               // coupled cycles answer only after PCI ends
               state_nxt = posted_r ? VSW_IDLE : VSW_REPLY;
            end
         end
         VSW_REPLY: begin
            state_nxt = posted_r ? VSW_ISSUE : VSW_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_r <= VSW_IDLE;
         addr_r <= 32'h00000000;
         space_r <= VSW_PCI_MEM;
         write_r <= 1'b0;
         wdata_r <= 32'h00000000;
         vrd_r <= 32'h00000000;
         wide_r <= 1'b0;
         lock_r <= 1'b0;
         pref_r <= 1'b0;
         posted_r <= 1'b0;
         cnt_r <= '0;
      end else if (ce) begin
         state_r <= state_nxt;
         addr_r <= addr_nxt;
         space_r <= space_nxt;
         write_r <= write_nxt;
         wdata_r <= wdata_nxt;
         vrd_r <= vrd_nxt;
         wide_r <= wide_nxt;
         lock_r <= lock_nxt;
         pref_r <= pref_nxt;
         posted_r <= posted_nxt;
         cnt_r <= cnt_nxt;
      end
   end

endmodule : vsw_window
`default_nettype wire

//--- verification/vsw_pci_model.sv
// PCI target model answering the window's forwarded requests
`timescale 1ns/1ns
`default_nettype none
module vsw_pci_model (
   // Clock, reset, latency
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [2:0] lat,
   // Request from the window
   input wire logic pciReq,
   input wire logic [31:0] pciAddr,
   input wire logic pciWrite,
   input wire logic [31:0] pciWdata,
   // Completion
   output logic pciDone,
   output logic [31:0] pciRdata,
   output logic [31:0] lastWr
);
   logic [2:0] cnt_r;
   logic done_r;
   logic [31:0] pat_r;
   // -----------------------------------------
   // Completion after a chosen wait
   // -----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b || !pciReq || done_r) begin
         cnt_r <= 3'h0;
         done_r <= 1'b0;
      end else if (cnt_r == lat) begin
         done_r <= 1'b1;
      end else begin
         cnt_r <= cnt_r + 3'h1;
      end
   end
   // Moving pattern so stale data never looks valid
   always_ff @(posedge sys_clk) begin
      pat_r <= rst_b ? pat_r + 32'h9E3779B9 : 32'h0;
      if (done_r && pciWrite) begin
         lastWr <= pciWdata;
      end
   end
   assign pciDone = done_r;
   assign pciRdata = done_r ? (pciAddr ^ 32'hA5A55A5A) : pat_r;
endmodule : vsw_pci_model
`default_nettype wire

//--- verification/vsw_window_checker.sv
// Port assertions for the inbound slave window
`timescale 1ns/1ns
`default_nettype none
module vsw_window_checker import vsw_pkg::*; #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Inbound side
   input wire logic busMasterEnable,
   input wire logic vmeClaim,
   input wire logic vmeAck,
   input wire logic [31:0] vmeAddr,
   input wire logic vmeRmw,
   // PCI side
   input wire logic pciReq,
   input wire logic [31:0] pciAddr,
   input wire logic [1:0] pciSpace,
   input wire logic pciWrite,
   input wire logic pciLock,
   input wire logic pciPrefetch,
   input wire logic pciPosted,
   input wire logic pciDone
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);
   // -----------------------------------------
   // Sequences and assertions
   // -----------------------------------------
   sequence s_fast;
      vmeClaim ##1 vmeAck;
   endsequence
   sequence s_post;
      pciPosted ##1 (pciReq && pciWrite);
   endsequence
   master_gate_a: assert property (vmeClaim |-> busMasterEnable)
      else $error("claim without bus master enable");
   claim_issue_a: assert property (vmeClaim |=> (pciReq || vmeAck))
      else $error("claim not followed by request or ack");
   post_order_a: assert property (s_fast |-> s_post)
      else $error("early ack without posted write");
   coupled_ack_a: assert property (pciReq && pciDone && !pciPosted |=> vmeAck)
      else $error("coupled cycle not acked after done");
   post_mem_a: assert property (pciReq && pciPosted |-> pciSpace == VSW_PCI_MEM)
      else $error("posted cycle outside memory space");
   pref_mem_a: assert property (pciReq && pciPrefetch |-> pciSpace == VSW_PCI_MEM)
      else $error("prefetch outside memory space");
   low_pass_a: assert property (vmeClaim |=> pciAddr[15:0] == $past(vmeAddr[15:0]))
      else $error("low address half changed");
   lock_rmw_a: assert property (pciLock |-> vmeRmw || $past(vmeRmw))
      else $error("lock held outside rmw");
   req_hold_a: assert property (pciReq && !pciDone |=> pciReq && $stable(pciAddr))
      else $error("request dropped before done");
endmodule : vsw_window_checker
bind vsw_window vsw_window_checker #(.CNT_W(CNT_W)) vsw_window_checker_inst (
   .sys_clk(sys_clk), .rst_b(rst_b), .busMasterEnable(busMasterEnable),
   .vmeClaim(vmeClaim), .vmeAck(vmeAck), .vmeAddr(vmeAddr), .vmeRmw(vmeRmw),
   .pciReq(pciReq), .pciAddr(pciAddr), .pciSpace(pciSpace), .pciWrite(pciWrite),
   .pciLock(pciLock), .pciPrefetch(pciPrefetch), .pciPosted(pciPosted), .pciDone(pciDone));
`default_nettype wire

//--- verification/test_vme_slave_window_decode.sv
// Self-checking bench for the inbound slave window
`timescale 1ns/1ns
`default_nettype none
module test_vme_slave_window_decode;
   import vsw_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic vmeBusReset = 1'b0, busMasterEnable = 1'b0;
   logic vmeReq = 1'b0, vmeWrite = 1'b0, vmeRmw = 1'b0;
   logic [31:0] vmeAddr = 32'h0, vmeWdata = 32'h0, vmeRdata;
   logic [5:0] vmeAm = 6'h0;
   logic vmeClaim, vmeAck, pciReq, pciWrite, pciWide, pciLock, pciPrefetch, pciPosted, pciDone;
   logic [31:0] pciAddr, pciWdata, pciRdata, lastWr, cAddr, rd;
   logic [1:0] pciSpace, cSpace;
   logic [2:0] lat = 3'h0;
   logic cPost, cPref, cWide, cLock, acked, ackFirst, gotReq;
   logic [7:0] qs [15] = '{8'hF1, 8'hF2, 8'hF6, 8'hF7, 8'hF3, 8'hF2, 8'h72, 8'h72,
      8'hB2, 8'hB2, 8'h32, 8'hD2, 8'hD2, 8'hE2, 8'hC2};
   logic [5:0] qa [15] = '{6'h39, 6'h09, 6'h10, 6'h18, 6'h39, 6'h39, 6'h09, 6'h0A,
      6'h0A, 6'h09, 6'h09, 6'h09, 6'h0D, 6'h0D, 6'h09};
   logic [14:0] qh = 15'b010100101001111;
   logic [31:0] ra [4] = '{32'h0FFFFFFC, 32'h10000000, 32'h1FFFFFFC, 32'h20000000};
   int fails = 0;
   int n_tests = 0;
   always #5 sys_clk = ~sys_clk;
   vsw_window #(.CNT_W(8)) vsw_window_inst (.sys_clk, .rst_b, .ce(1'b1), .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .vmeBusReset,
      .busMasterEnable, .vmeReq, .vmeAddr, .vmeAm, .vmeWrite, .vmeRmw, .vmeWdata, .vmeClaim, .vmeAck,
      .vmeRdata, .pciReq, .pciAddr, .pciSpace, .pciWrite, .pciWdata, .pciWide, .pciLock, .pciPrefetch,
      .pciPosted, .pciDone, .pciRdata);
   vsw_pci_model vsw_pci_model_inst (.sys_clk, .rst_b, .lat, .pciReq, .pciAddr, .pciWrite, .pciWdata,
      .pciDone, .pciRdata, .lastWr);
   // -----------------------------------------
   // Compare, report and bus tasks
   // -----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic chkb(input string nm, input logic exp, got);
      chk(nm, {31'h0, exp}, {31'h0, got});
   endtask : chkb
   task automatic finish_test();
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   task automatic bus_wait();
      for (int i = 0; i < 20; i++) begin
         @(posedge sys_clk);
         if (hreadyout === 1'b1) return;
      end
      fails++;
      finish_test();
   endtask : bus_wait
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b1;
      bus_wait();
      htrans <= 2'h0;
      hwdata <= d;
      bus_wait();
   endtask : wr
   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'b0;
      bus_wait();
      htrans <= 2'h0;
      bus_wait();
      chk(nm, exp, hrdata);
   endtask : rdc
   // One inbound cycle; waits for the ack and for the PCI request to end
   task automatic cyc(input logic [31:0] a, input logic [5:0] m, input logic w, r, hit);
      vmeReq <= 1'b1;
      vmeAddr <= a;
      vmeAm <= m;
      vmeWrite <= w;
      vmeRmw <= r;
      vmeWdata <= ~a;
      acked = 1'b0;
      gotReq = 1'b0;
      for (int i = 0; i < 30; i++) begin
         @(posedge sys_clk);
         if (pciReq === 1'b1 && !gotReq) begin
            gotReq = 1'b1;
            ackFirst = acked;
            {cAddr, cSpace, cPost} = {pciAddr, pciSpace, pciPosted};
            {cPref, cWide, cLock} = {pciPrefetch, pciWide, pciLock};
         end
         if (vmeAck === 1'b1) begin
            acked = 1'b1;
            rd = vmeRdata;
            vmeReq <= 1'b0;
            vmeRmw <= 1'b0;
         end
         if (acked && gotReq && pciReq === 1'b0) break;
      end
      if (!acked) begin
         vmeReq <= 1'b0;
         vmeRmw <= 1'b0;
      end
      // One idle edge so the next call never re-raises in this step
      @(posedge sys_clk);
      chkb("claim", hit, acked);
      chkb("pci request", hit, gotReq);
      if (hit && !acked) finish_test();
   endtask : cyc
   // -----------------------------------------
   // Scenarios
   // -----------------------------------------
   task automatic t_regs();
      rdc("ctl reset", VSW_CTL_OFS, VSW_CTL_RESET);
      rdc("base reset", VSW_BASE_OFS, 32'h0);
      rdc("bound reset", VSW_BOUND_OFS, 32'h0);
      rdc("offset reset", VSW_XOFS_OFS, 32'h0);
      wr(VSW_CTL_OFS, 32'hFFFFFFFF);
      rdc("ctl mask", VSW_CTL_OFS, VSW_CTL_WMASK);
      wr(VSW_BASE_OFS, 32'hFFFFFFFF);
      rdc("base bits", VSW_BASE_OFS, 32'hFFFF0000);
      wr(12'hF00, 32'hFFFFFFFF);
      rdc("unmapped", 12'hF00, 32'h0);
      vmeBusReset <= 1'b1;
      @(posedge sys_clk);
      vmeBusReset <= 1'b0;
      rdc("ctl vme reset", VSW_CTL_OFS, VSW_CTL_RESET);
      rdc("base vme reset", VSW_BASE_OFS, 32'h0);
      chkb("okay", 1'b0, hresp);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_gate();
      wr(VSW_CTL_OFS, 32'h00F20000);
      cyc(32'h00001000, 6'h09, 1'b0, 1'b0, 1'b0);
      wr(VSW_CTL_OFS, 32'h80F20000);
      busMasterEnable <= 1'b0;
      cyc(32'h00001000, 6'h09, 1'b0, 1'b0, 1'b0);
      busMasterEnable <= 1'b1;
      lat <= 3'h3;
      cyc(32'h00001234, 6'h09, 1'b0, 1'b0, 1'b1);
      chk("read data", 32'h00001234 ^ 32'hA5A55A5A, rd);
      chk("space mem", {30'h0, VSW_PCI_MEM}, {30'h0, cSpace});
      $display("t_gate done");
   endtask : t_gate
   task automatic t_range();
      wr(VSW_BASE_OFS, 32'h10000000);
      wr(VSW_BOUND_OFS, 32'h20000000);
      for (int i = 0; i < 4; i++) begin
         cyc(ra[i], 6'h09, 1'b0, 1'b0, i == 1 || i == 2);
      end
      wr(VSW_BOUND_OFS, 32'h0);
      cyc(32'hFFFFFFFC, 6'h09, 1'b0, 1'b0, 1'b1);
      cyc(32'h0FFFFFFC, 6'h09, 1'b0, 1'b0, 1'b0);
      wr(VSW_BASE_OFS, 32'h0);
      $display("t_range done");
   endtask : t_range
   task automatic t_qual();
      for (int i = 0; i < 15; i++) begin
         wr(VSW_CTL_OFS, {8'h80, qs[i], 16'h0});
         cyc(32'h00001000, qa[i], 1'b0, 1'b0, qh[i]);
      end
      $display("t_qual done");
   endtask : t_qual
   task automatic t_xlate();
      wr(VSW_CTL_OFS, 32'h80F20000);
      wr(VSW_XOFS_OFS, 32'hF0000000);
      cyc(32'h1234ABCD, 6'h09, 1'b0, 1'b0, 1'b1);
      chk("negative offset", 32'h0234ABCD, cAddr);
      wr(VSW_XOFS_OFS, 32'h00010000);
      cyc(32'hFFFF1234, 6'h09, 1'b0, 1'b0, 1'b1);
      chk("wrapped sum", 32'h00001234, cAddr);
      wr(VSW_XOFS_OFS, 32'h0);
      $display("t_xlate done");
   endtask : t_xlate
   task automatic t_post();
      lat <= 3'h1;
      for (int s = 0; s < 4; s++) begin
         wr(VSW_CTL_OFS, s < 3 ? 32'hE0F200C0 | s : 32'h80F20000);
         cyc(32'h00005678, 6'h09, 1'b1, 1'b0, 1'b1);
         chkb("posted", s == 0, cPost);
         chkb("ack first", s == 0, ackFirst);
         chk("space", s % 3, {30'h0, cSpace});
         chk("write data", ~32'h00005678, lastWr);
         cyc(32'h00005678, 6'h09, 1'b0, 1'b1, 1'b1);
         chkb("prefetch", s == 0, cPref);
         chkb("wide", s < 3, cWide);
         chkb("lock", s < 3, cLock);
      end
      rdc("status", VSW_STAT_OFS, 32'h00001600);
      $display("t_post done");
   endtask : t_post
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      busMasterEnable <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_gate();
      t_range();
      t_qual();
      t_xlate();
      t_post();
      finish_test();
   end
endmodule : test_vme_slave_window_decode
`default_nettype wire
